//--- verilog/scpr_top.sv
`timescale 1ns/1ps
module scpr_top #(
   parameter int RELEASE_CYC = scpr_pkg::RELEASE_CYC_DEF
) (
   // System
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Serial link
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_sdi,
   // Supply comparators and external reset
   input wire logic i_main_supply_ok,
   input wire logic i_low_rail_feedback_low,
   input wire logic i_low_rail_feedback_high,
   input wire logic i_ext_rst_n,
   // Driver mode and PWM pins
   input wire logic [1:0] i_driver_type_select,
   input wire logic [1:0] i_driver_pwm_input,
   // Outputs
   output logic o_rst_n,
   output logic o_high_rail_enable,
   output logic [1:0] o_drv_active,
   output logic [1:0] o_drv_step_mode,
   output logic [1:0] o_drv_dc_pwm,
   output logic [7:0] o_phase_current,
   output logic [3:0] o_phase_dir
);
   import scpr_pkg::*;

   // ==========================================
   // Link domain: shift register on the serial clock
   logic [WORD_W-1:0] shift_r;
   logic [CNT_W-1:0] cnt_r;
   logic [WORD_W-1:0] held_r;
   logic held_tgl_r;
   logic end_tgl_r;
   logic start_ack_r;
   logic link_rst_r;
   logic word_full;

   // Link reset comes from the system side; the serial clock is stopped then
   always_ff @(posedge i_clk_sys) begin
      link_rst_r <= i_srst;
   end

   // No reset: only a full frame is ever copied out
   always_ff @(posedge i_sclk) begin
      if (!i_cs_n) begin
         shift_r <= {i_sdi, shift_r[WORD_W-1:1]};
      end
   end

   // First clock after a select rise restarts the count; saturates at a full word
   // End toggle is quiet since the last select rise, long before this clock
   always_ff @(posedge i_sclk or posedge link_rst_r) begin
      if (link_rst_r) begin
         cnt_r <= '0;
         start_ack_r <= 1'b0;
      end else if (!i_cs_n) begin
         start_ack_r <= end_tgl_r;
         if (start_ack_r != end_tgl_r) begin
            cnt_r <= 4'h1;
         end else if (cnt_r != BIT_COUNT) begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end
   assign word_full = (cnt_r == BIT_COUNT);

   // Select rising edge closes the frame; a short frame is dropped
   always_ff @(posedge i_cs_n) begin
      if (word_full) begin
         held_r <= shift_r;
      end
   end

   // Every frame end flips the end toggle; a full word flips the event too
   always_ff @(posedge i_cs_n or posedge link_rst_r) begin
      if (link_rst_r) begin
         end_tgl_r <= 1'b0;
         held_tgl_r <= 1'b0;
      end else begin
         end_tgl_r <= ~end_tgl_r;
         if (word_full) begin
            held_tgl_r <= ~held_tgl_r;
         end
      end
   end

   // ==========================================
   // System domain: crossing of the word event
   logic tgl_s1_r;
   logic tgl_s2_r;
   logic tgl_s3_r;
   always_ff @(posedge i_clk_sys) begin
      tgl_s1_r <= held_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
   end

   // Pin synchronisers
   logic [2:0] pin_s1_r;
   logic [2:0] pin_s2_r;
   always_ff @(posedge i_clk_sys) begin
      pin_s1_r <= {i_main_supply_ok, i_low_rail_feedback_low, i_ext_rst_n};
      pin_s2_r <= pin_s1_r;
   end
   logic [3:0] drv_s1_r;
   logic [3:0] drv_s2_r;
   always_ff @(posedge i_clk_sys) begin
      drv_s1_r <= {i_driver_type_select, i_driver_pwm_input};
      drv_s2_r <= drv_s1_r;
   end
   logic hi_s1_r;
   logic hi_s2_r;
   always_ff @(posedge i_clk_sys) begin
      hi_s1_r <= i_low_rail_feedback_high;
      hi_s2_r <= hi_s1_r;
   end

   // ==========================================
   // Reset generator
   scpr_rst_state_type st_r;
   logic [TMR_W-1:0] tmr_r;
   logic supply_ok;
   logic fb_low;
   logic rst_n_r;
   assign supply_ok = pin_s2_r[2];
   assign fb_low = pin_s2_r[1];

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         st_r <= SCPR_HOLD;
         tmr_r <= '0;
      end else begin
         case (st_r)
            SCPR_RUN: begin
               tmr_r <= '0;
               if (!supply_ok) begin
                  st_r <= SCPR_HOLD;
               end else if (fb_low) begin
                  st_r <= SCPR_PERSIST;
               end
            end
            SCPR_PERSIST: begin
               if (!supply_ok) begin
                  st_r <= SCPR_HOLD;
                  tmr_r <= '0;
               end else if (!fb_low) begin
                  st_r <= SCPR_RUN;
                  tmr_r <= '0;
               end else if (tmr_r == TMR_W'(PERSIST_CYC - 1)) begin
                  st_r <= SCPR_HOLD;
                  tmr_r <= '0;
               end else begin
                  tmr_r <= tmr_r + 1'b1;
               end
            end
            SCPR_HOLD: begin
               if (!supply_ok || !hi_s2_r) begin
                  tmr_r <= '0;
               end else if (tmr_r == TMR_W'(RELEASE_CYC - 1)) begin
                  st_r <= SCPR_RUN;
                  tmr_r <= '0;
               end else begin
                  tmr_r <= tmr_r + 1'b1;
               end
            end
            default: begin
               st_r <= SCPR_HOLD;
               tmr_r <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         rst_n_r <= 1'b0;
      end else begin
         rst_n_r <= (st_r != SCPR_HOLD);
      end
   end
   assign o_rst_n = rst_n_r;

   // ==========================================
   // Input register: all bits applied in parallel
   logic [WORD_W-1:0] word_r;
   logic any_rst;
   assign any_rst = i_srst || !rst_n_r || !pin_s2_r[0];
   // The held word is stable for many system cycles once the toggle arrives
   always_ff @(posedge i_clk_sys) begin
      if (any_rst) begin
         word_r <= WORD_RST;
      end else if (tgl_s2_r != tgl_s3_r) begin
         word_r <= held_r;
      end
   end

   // ==========================================
   // Driver controls; no serial output exists, port is write-only
   logic en;
   assign en = word_r[POS_HR_EN] && !any_rst;
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_high_rail_enable <= 1'b0;
         o_drv_active <= 2'h0;
         o_drv_step_mode <= 2'h0;
         o_drv_dc_pwm <= 2'h0;
         o_phase_current <= 8'h00;
         o_phase_dir <= 4'h0;
      end else begin
         o_high_rail_enable <= word_r[POS_HR_EN];
         o_drv_active <= {2{en}};
         o_drv_step_mode <= drv_s2_r[3:2];
         o_drv_dc_pwm <= en ? (drv_s2_r[1:0] & ~drv_s2_r[3:2]) : 2'h0;
         o_phase_current <= {word_r[POS_D1_PHA +: 2], word_r[POS_D1_PHB +: 2],
                             word_r[POS_D2_PHA +: 2], word_r[POS_D2_PHB +: 2]};
         o_phase_dir <= {word_r[POS_D1_PHA + 2], word_r[POS_D1_PHB + 2],
                         word_r[POS_D2_PHA + 2], word_r[POS_D2_PHB + 2]};
      end
   end
endmodule : scpr_top

//--- verilog/scpr_pkg.sv
package scpr_pkg;
   // ==========================================
   // Serial word layout
   localparam int WORD_W = 13;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] BIT_COUNT = 4'hD;
   // Bit 1 (first shifted) is index 0
   localparam int POS_HR_EN = 0;
   localparam logic [WORD_W-1:0] WORD_RST = 13'h0DB7;
   // Step-mode field positions (index of the two current bits, then direction)
   localparam int POS_D2_PHB = 1;
   localparam int POS_D2_PHA = 4;
   localparam int POS_D1_PHB = 7;
   localparam int POS_D1_PHA = 10;
   // ==========================================
   // Reset timing at 200 MHz
   localparam int CLK_MHZ = 200;
   localparam int PERSIST_US = 20;
   localparam int PERSIST_CYC = PERSIST_US * CLK_MHZ;
   localparam int RELEASE_MS = 33;
   localparam int RELEASE_CYC_DEF = RELEASE_MS * 1000 * CLK_MHZ;
   localparam int TMR_W = 23;
   // ==========================================
   typedef enum logic [1:0] {
      SCPR_RUN = 2'b00,
      SCPR_PERSIST = 2'b01,
      SCPR_HOLD = 2'b10
   } scpr_rst_state_type;
endpackage : scpr_pkg

//--- dv/scpr_monitor.sv
`timescale 1ns/1ps
// =====
// Checker
module scpr_monitor #(parameter int RELEASE_CYC = 200) (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic i_cs_n,
   input wire logic i_main_supply_ok,
   input wire logic i_ext_rst_n,
   input wire logic i_low_rail_feedback_low,
   input wire logic i_low_rail_feedback_high,
   input wire logic o_rst_n,
   input wire logic o_high_rail_enable,
   input wire logic [1:0] o_drv_active,
   input wire logic [1:0] o_drv_step_mode,
   input wire logic [1:0] o_drv_dc_pwm,
   input wire logic [7:0] o_phase_current,
   input wire logic [3:0] o_phase_dir
);
   logic [15:0] lo_r, hi_r, cs_r, sup_r;
   logic [12:0] word_seen;
   assign word_seen = {o_high_rail_enable, o_phase_current, o_phase_dir};
   // Saturate so a long soak never wraps
   always_ff @(posedge i_clk_sys) begin
      lo_r <= (i_srst || !i_low_rail_feedback_low) ? 16'h0 : lo_r + {15'h0, ~&lo_r};
      hi_r <= (i_srst || !i_low_rail_feedback_high) ? 16'h0 : hi_r + {15'h0, ~&hi_r};
      sup_r <= (i_srst || !i_main_supply_ok) ? 16'h0 : sup_r + {15'h0, ~&sup_r};
      cs_r <= i_srst ? 16'hFFFF : ($rose(i_cs_n) ? 16'h0 : cs_r + {15'h0, ~&cs_r});
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   chk_rst_drv_off: assert property (!o_rst_n [*2] |-> o_drv_active == 2'h0)
      else $error("drivers on in reset");
   chk_en_drv_off: assert property (!o_high_rail_enable [*2] |-> o_drv_active == 2'h0)
      else $error("drivers on while disabled");
   // Supply loss resets at once, so only a supply-good fall is held to persistence
   chk_persist_min: assert property ($fell(o_rst_n) && sup_r > 16'h8
      |-> lo_r >= 16'h07D0) else $error("reset too early");
   chk_persist_max: assert property (lo_r >= 16'h1770 |-> !o_rst_n)
      else $error("reset too late");
   chk_release_min: assert property ($rose(o_rst_n)
      |-> hi_r + 16'h2 >= RELEASE_CYC && sup_r + 16'h2 >= RELEASE_CYC)
      else $error("release too early");
   chk_release_max: assert property (hi_r >= RELEASE_CYC + 16
      && sup_r >= RELEASE_CYC + 16 |-> o_rst_n) else $error("release too late");
   chk_word_hold: assert property ($changed(word_seen) && cs_r > 16'hA
      && $past(o_rst_n, 4) && $past(i_ext_rst_n, 4) |-> ##[0:2] !o_rst_n)
      else $error("word changed without frame");
   chk_pwm_mode: assert property ($stable(o_drv_step_mode) [*3]
      |-> (o_drv_step_mode & o_drv_dc_pwm) == 2'h0)
      else $error("pwm in step mode");
endmodule : scpr_monitor
bind scpr_top scpr_monitor #(.RELEASE_CYC(RELEASE_CYC)) scpr_monitor_inst (
   .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_cs_n(i_cs_n),
   .i_main_supply_ok(i_main_supply_ok), .i_ext_rst_n(i_ext_rst_n),
   .i_low_rail_feedback_low(i_low_rail_feedback_low),
   .i_low_rail_feedback_high(i_low_rail_feedback_high), .o_rst_n(o_rst_n),
   .o_high_rail_enable(o_high_rail_enable), .o_drv_active(o_drv_active),
   .o_drv_step_mode(o_drv_step_mode), .o_drv_dc_pwm(o_drv_dc_pwm),
   .o_phase_current(o_phase_current), .o_phase_dir(o_phase_dir));

//--- dv/scpr_ctrl_model.sv
`timescale 1ns/1ps
// =====
// Controller side, link clock only inside frames
module scpr_ctrl_model (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_sdi
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sdi = 1'b0;
   end
   // Fewer than 13 bits makes a cut frame, which the block must drop
   task automatic send(input logic [12:0] w, input int nbits);
      o_cs_n = 1'b0;
      #250;
      for (int b = 0; b < nbits; b++) begin
         o_sdi = w[b];
         #62.5;
         o_sclk = 1'b1;
         #62.5;
         o_sclk = 1'b0;
      end
      #250;
      o_cs_n = 1'b1;
      o_sdi = ~o_sdi; // Released line shows no stale bit
      #250;
   endtask : send
endmodule : scpr_ctrl_model

//--- dv/scpr_tb_top.sv
`timescale 1ns/1ps
module scpr_tb_top;
   import scpr_pkg::*;
   logic i_clk_sys, i_srst, i_sclk, i_cs_n, i_sdi, fb_lo, fb_hi, o_rst_n, o_en;
   logic sup_ok, ext_n;
   logic [1:0] ts, pwm, en, o_act, o_step, o_pwm;
   logic [7:0] o_cur;
   logic [3:0] o_dir;
   logic [12:0] w, outs, last_w;
   int n_fail, compares, seed, nb;
   assign outs = {o_en, o_cur, o_dir};
   initial begin
      i_clk_sys = 1'b0;
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end
   scpr_ctrl_model scpr_ctrl_model_inst (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdi(i_sdi));
   scpr_top #(.RELEASE_CYC(200)) scpr_top_inst (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
      .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_sdi(i_sdi), .i_main_supply_ok(sup_ok),
      .i_low_rail_feedback_low(fb_lo), .i_low_rail_feedback_high(fb_hi),
      .i_ext_rst_n(ext_n), .i_driver_type_select(ts), .i_driver_pwm_input(pwm),
      .o_rst_n(o_rst_n), .o_high_rail_enable(o_en), .o_drv_active(o_act),
      .o_drv_step_mode(o_step), .o_drv_dc_pwm(o_pwm), .o_phase_current(o_cur),
      .o_phase_dir(o_dir));
   function automatic logic [12:0] exp_out(input logic [12:0] x);
      return {x[0], x[11:10], x[8:7], x[5:4], x[2:1], x[12], x[9], x[6], x[3]};
   endfunction : exp_out
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : tick
   task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic finish_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic wait_up;
      for (int k = 0; k < 2000 && o_rst_n !== 1'b1; k++) tick(1);
      chk("rst release", o_rst_n, 1'b1);
   endtask : wait_up
   initial begin
      #150000;
      n_fail++;
      finish_test;
   end
   initial begin
      seed = 32'hd74776b1;
      {i_srst, fb_lo, fb_hi, sup_ok, ext_n, ts, pwm, n_fail, compares} = {5'b10111, 4'h0, 64'h0};
      tick(8);
      i_srst = 1'b0;
      wait_up;
      chk("reset word", outs, exp_out(WORD_RST));
      for (int i = 0; i < 8; i++) begin
         w = (i == 0) ? 13'h1FFE : ((i == 1) ? 13'h0001 : 13'($random(seed)));
         nb = (i == 3) ? 5 : 13;
         ts = 2'(i);
         pwm = 2'($random(seed));
         scpr_ctrl_model_inst.send(w, nb);
         tick(12);
         if (nb == 13) last_w = w;
         en = {2{last_w[0]}};
         chk("word", outs, exp_out(last_w));
         chk("active", o_act, en);
         chk("mode", o_step, ts);
         chk("pwm", o_pwm, pwm & ~ts & en);
      end
      {fb_lo, fb_hi} = 2'b10;
      tick(1900);
      chk("rst early", o_rst_n, 1'b1);
      tick(4200);
      chk("rst late", o_rst_n, 1'b0);
      chk("drv in rst", o_act, 2'h0);
      {fb_lo, fb_hi} = 2'b01;
      tick(150);
      chk("rst hold", o_rst_n, 1'b0);
      wait_up;
      chk("reload", outs, exp_out(WORD_RST));
      w = 13'h1249;
      scpr_ctrl_model_inst.send(w, 13);
      tick(12);
      chk("word after rst", outs, exp_out(w));
      ext_n = 1'b0;
      tick(6);
      chk("ext word", outs, exp_out(WORD_RST));
      chk("ext drv", o_act, 2'h0);
      chk("ext rst out", o_rst_n, 1'b1);
      ext_n = 1'b1;
      tick(6);
      chk("ext drv back", o_act, {2{WORD_RST[0]}});
      sup_ok = 1'b0;
      tick(8);
      chk("sup rst", o_rst_n, 1'b0);
      chk("sup drv", o_act, 2'h0);
      sup_ok = 1'b1;
      wait_up;
      finish_test;
   end
endmodule : scpr_tb_top
